// File: design/frequency_sweep_control.sv
// Sweep configuration registers, trigger selection and ramp sequencer
// What this block does
// - Shape bit one: symmetric ramps on up set only; zero: asymmetric.
// - Symmetric falling ramp mirrors rising dwell, step, count; reversed.
// - Up step joins 0x12[29:0], 0x13[17:0]; up dwell joins 0x10, 0x11.
// - Up step count upper 30 bits come from 0x14[29:0].
// - Asymmetric down dwell joins 0x06 upper and 0x07[17:0] lower.
// - Asymmetric down step high part from 0x19[29:0]; low part from 0x1a[17:0].
// - Asymmetric down step count joins 0x0c[29:0] and 0x0d[17:0].
// - Trigger source bit zero selects register trigger, one the pin.
// - Writing one to the command bit fires one register-source trigger.
// - With pin source the trigger comes from the GPIO trigger pin.
// - Delay-enable bit adds programmable delay; clear acts at once.
// - Enabled delay waits the 21-bit count of reference periods.
// - Delay of one takes effect at the next reference rising edge.
// - Sweep runs only while the sweep-enable bit is one.
// - Direction bit one starts rising, zero starts falling.
// - Autoseed reloads the 48-bit seed at the start of every ramp.
// - Step applied once per reference period for the programmed step count.
module frequency_sweep_control (
	// Clock, reset and enable
	input  wire logic                          core_clk,
	input  wire logic                          rst_b,
	input  wire logic                          ce,
	// Register port
	input  wire logic                          regWrEn,
	input  wire logic                          regRdEn,
	input  wire logic [sweep_pkg::ADDR_W-1:0]  regAddr,
	input  wire logic [sweep_pkg::DATA_W-1:0]  regWrData,
	output logic      [sweep_pkg::DATA_W-1:0]  regRdData,
	// External trigger pin
	input  wire logic                          gpioTriggerPin,
	// Sweep outputs to the delta_sigma_modulator
	output logic      [sweep_pkg::WIDE_W-1:0]  freqOffset,
	output logic                               rampUp,
	output logic                               rampActive,
	output logic                               dwellActive,
	output logic                               seedLoad,
	output logic      [sweep_pkg::WIDE_W-1:0]  seedValue,
	output logic                               sweepTrigger
);
	import sweep_pkg::*;

	// Register storage, one word per address
	logic [DATA_W-1:0] regFile [0:31];

	// Address decode: mapped, writable registers
	function automatic logic isMapped(input logic [4:0] a);
		if (a == GPIO_MASTER_CONTROL || a == REFERENCE_DIVIDER)
			isMapped = 1'b1;
		else if (a == TRIGGER_DELAY_COUNT || a == GPIO_DIRECTION)
			isMapped = 1'b1;
		else if (a == DOWN_DWELL_HIGH || a == DOWN_DWELL_LOW)
			isMapped = 1'b1;
		else if (a == SEED_HIGH || a == SEED_LOW)
			isMapped = 1'b1;
		else if (a == DOWN_STEP_COUNT_HIGH || a == DOWN_STEP_COUNT_LOW)
			isMapped = 1'b1;
		else if (a == SWEEP_CONTROL)
			isMapped = 1'b1;
		else if (a >= UP_DWELL_HIGH && a <= UP_STEP_COUNT_LOW)
			isMapped = 1'b1;
		else if (a == DOWN_STEP_SIZE_HIGH || a == DOWN_STEP_SIZE_LOW)
			isMapped = 1'b1;
		else
			isMapped = 1'b0;
	endfunction : isMapped

	// Choose the parameter of the ramp direction in use
	function automatic logic [47:0] pickSet(input logic up,
		input logic symm, input logic [47:0] upVal,
		input logic [47:0] downVal);
		pickSet = (up || symm) ? upVal : downVal;
	endfunction : pickSet

	sweep_state_e      state;
	logic [47:0]       stepsLeft;
	logic [47:0]       dwellLeft;
	logic [2:0]        pinSync;
	logic              pinLevel;
	logic              pinEdge;
	logic              spiTrig;
	logic              pinTrig;
	logic              trigRaw;

	// Control fields
	logic [DATA_W-1:0] ctrl;
	logic              symm;
	logic              oneWay;
	logic              autoMode;
	logic              srcPin;
	logic [47:0]       upStep;
	logic [47:0]       downStep;
	logic [47:0]       upCount;
	logic [47:0]       downCount;
	logic [47:0]       upDwell;
	logic [47:0]       downDwell;
	logic [47:0]       activeStep;
	logic              startRamp;
	logic              nextDir;

	assign ctrl     = regFile[SWEEP_CONTROL];
	assign symm     = ctrl[SHAPE_BIT];
	assign oneWay   = ctrl[ONE_WAY_BIT];
	assign autoMode = ctrl[AUTO_HI_BIT] && ctrl[AUTO_LO_BIT];
	assign srcPin   = ctrl[TRIG_SRC_BIT];

	// Wide sweep parameters
	assign upStep    = join48(regFile[UP_STEP_SIZE_HIGH],
		regFile[UP_STEP_SIZE_LOW]);
	assign upDwell   = join48(regFile[UP_DWELL_HIGH],
		regFile[UP_DWELL_LOW]);
	assign upCount   = join48(regFile[UP_STEP_COUNT_HIGH],
		regFile[UP_STEP_COUNT_LOW]);
	assign downDwell = join48(regFile[DOWN_DWELL_HIGH],
		regFile[DOWN_DWELL_LOW]);
	assign downStep  = join48(regFile[DOWN_STEP_SIZE_HIGH],
		regFile[DOWN_STEP_SIZE_LOW]);
	assign downCount = join48(regFile[DOWN_STEP_COUNT_HIGH],
		regFile[DOWN_STEP_COUNT_LOW]);

	// Symmetric ramps reuse the up set in both directions
	assign activeStep = pickSet(rampUp, symm, upStep, downStep);

	// Register writes; trigger command bit never stored
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			for (int i = 0; i < 32; i++) begin
				regFile[i] <= REG_RESET;
			end
		end else if (ce && regWrEn && isMapped(regAddr)) begin
			regFile[regAddr] <= regWrData;
			if (regAddr == SWEEP_CONTROL) begin
				regFile[regAddr][TRIG_CMD_BIT] <= 1'b0;
			end
		end
	end

	// Read data, status word shows the sequencer
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			regRdData <= REG_RESET;
		end else if (ce && regRdEn) begin
			if (regAddr == SWEEP_STATUS)
				regRdData <= {24'h0, rampUp, pinLevel, state};
			else if (isMapped(regAddr))
				regRdData <= regFile[regAddr];
			else
				regRdData <= REG_RESET;
		end
	end

	// Pin synchroniser; a change counts once stages two and three agree
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			pinSync  <= 3'h0;
			pinLevel <= 1'b0;
		end else if (ce) begin
			pinSync <= {pinSync[1:0], gpioTriggerPin};
			if (pinSync[1] == pinSync[2]) begin
				pinLevel <= pinSync[2];
			end
		end
	end

	assign pinEdge = (pinSync[1] == pinSync[2]) && pinSync[2] && !pinLevel;

	// Trigger source selection
	assign spiTrig = ce && regWrEn && regAddr == SWEEP_CONTROL
		&& regWrData[TRIG_CMD_BIT] && !regWrData[TRIG_SRC_BIT];
	assign pinTrig = ce && pinEdge && srcPin
		&& regFile[GPIO_MASTER_CONTROL][GPIO_MASTER_BIT]
		&& !regFile[GPIO_DIRECTION][TRIG_PIN_DIR_BIT];
	assign trigRaw = spiTrig || pinTrig;

	trigger_delay u_delay (
		.core_clk   (core_clk),
		.rst_b      (rst_b),
		.ce         (ce),
		.delayEn    (ctrl[DELAY_EN_BIT]),
		.delayCount (regFile[TRIGGER_DELAY_COUNT][20:0]),
		.trigIn     (trigRaw),
		.trigOut    (sweepTrigger)
	);

	// Ramp start: trigger or automatic mode in wait, or auto two-way turn
	always_comb begin
		startRamp = 1'b0;
		nextDir   = rampUp;
		case (state)
			SW_WAIT: begin
				startRamp = sweepTrigger || autoMode;
			end
			SW_DWELL: begin
				if (dwellLeft <= 48'h1 && autoMode && !oneWay) begin
					startRamp = 1'b1;
					nextDir   = !rampUp;
				end
			end
			default: begin
				startRamp = 1'b0;
			end
		endcase
	end

	// Sweep sequencer
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			state      <= SW_IDLE;
			stepsLeft  <= WIDE_RESET;
			dwellLeft  <= WIDE_RESET;
			freqOffset <= WIDE_RESET;
			rampUp     <= 1'b1;
		end else if (ce) begin
			if (!ctrl[SWEEP_EN_BIT]) begin
				state      <= SW_IDLE;
				freqOffset <= WIDE_RESET;
			end else if (startRamp) begin
				rampUp    <= nextDir;
				stepsLeft <= pickSet(nextDir, symm, upCount, downCount);
				if (pickSet(nextDir, symm, upCount, downCount) == WIDE_RESET)
				begin
					state     <= SW_DWELL;
					dwellLeft <= pickSet(nextDir, symm, upDwell, downDwell);
				end else begin
					state <= SW_RAMP;
				end
			end else begin
				case (state)
					SW_IDLE: begin
						state  <= SW_WAIT;
						rampUp <= ctrl[DIR_BIT];
					end
					SW_RAMP: begin
						if (rampUp)
							freqOffset <= freqOffset + activeStep;
						else
							freqOffset <= freqOffset - activeStep;
						stepsLeft <= stepsLeft - 48'h1;
						if (stepsLeft <= 48'h1) begin
							state     <= SW_DWELL;
							dwellLeft <= pickSet(rampUp, symm, upDwell,
								downDwell);
						end
					end
					SW_DWELL: begin
						dwellLeft <= dwellLeft - 48'h1;
						if (dwellLeft <= 48'h1) begin
							state <= SW_WAIT;
							if (oneWay) begin
								freqOffset <= WIDE_RESET;
								rampUp     <= ctrl[DIR_BIT];
							end else begin
								rampUp <= !rampUp;
							end
						end
					end
					default: begin
						state <= state;
					end
				endcase
			end
		end
	end

	// Seed reload at each ramp start
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			seedLoad  <= 1'b0;
			seedValue <= WIDE_RESET;
		end else if (ce) begin
			seedLoad <= startRamp && ctrl[SWEEP_EN_BIT]
				&& ctrl[AUTOSEED_BIT];
			if (startRamp && ctrl[AUTOSEED_BIT]) begin
				seedValue <= join48(regFile[SEED_HIGH], regFile[SEED_LOW]);
			end
		end
	end

	assign rampActive  = (state == SW_RAMP);
	assign dwellActive = (state == SW_DWELL);

	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_b);

	sequence seq_ramp_step;
		ce && state == SW_RAMP && ctrl[SWEEP_EN_BIT] && !startRamp;
	endsequence
	sequence seq_dwell_hold;
		ce && state == SW_DWELL && dwellLeft > 48'h1
			&& ctrl[SWEEP_EN_BIT];
	endsequence

	a_sym_step_set: assert property (symm |-> activeStep == upStep)
		else $error("symmetric ramp not using up step");
	a_asym_down_step: assert property (
		!symm && !rampUp |-> activeStep == downStep)
		else $error("asymmetric falling ramp not using down step");
	a_spi_trigger: assert property (
		spiTrig && !ctrl[DELAY_EN_BIT] |-> sweepTrigger)
		else $error("register trigger write did not fire");
	a_pin_source: assert property (!srcPin |-> !pinTrig)
		else $error("pin trigger taken while register source chosen");
	a_sweep_gate: assert property (
		ce && !ctrl[SWEEP_EN_BIT] |=> state == SW_IDLE
			&& freqOffset == WIDE_RESET)
		else $error("sweep ran while disabled");
	a_seed_reload: assert property (
		ce && startRamp && ctrl[SWEEP_EN_BIT] && ctrl[AUTOSEED_BIT]
		|=> seedLoad)
		else $error("seed not reloaded at ramp start");
	a_ramp_step_add: assert property (seq_ramp_step |=>
		freqOffset == ($past(rampUp)
			? $past(freqOffset) + $past(activeStep)
			: $past(freqOffset) - $past(activeStep)))
		else $error("ramp step not applied");
	a_dwell_hold: assert property (seq_dwell_hold |=> $stable(freqOffset)
		&& state == SW_DWELL)
		else $error("frequency moved during dwell");
	a_start_dir: assert property (
		ce && state == SW_IDLE && ctrl[SWEEP_EN_BIT]
		|=> rampUp == $past(ctrl[DIR_BIT]))
		else $error("first ramp direction wrong");
	a_sym_mirror: assert property (
		ce && startRamp && symm && ctrl[SWEEP_EN_BIT]
		&& upCount != WIDE_RESET |=> stepsLeft == $past(upCount))
		else $error("symmetric ramp count not mirrored");

endmodule : frequency_sweep_control

// File: design/sweep_pkg.sv
// Shared constants, register map and types of the frequency-sweep control
package sweep_pkg;

	// Widths
	localparam int unsigned ADDR_W  = 5;
	localparam int unsigned DATA_W  = 30;
	localparam int unsigned WIDE_W  = 48;
	localparam int unsigned LOW_W   = 18;
	localparam int unsigned DELAY_W = 21;

	// Register offsets on the serial register port
	localparam logic [4:0] GPIO_MASTER_CONTROL  = 5'h01;
	localparam logic [4:0] REFERENCE_DIVIDER    = 5'h02;
	localparam logic [4:0] TRIGGER_DELAY_COUNT  = 5'h05;
	localparam logic [4:0] DOWN_DWELL_HIGH      = 5'h06;
	localparam logic [4:0] DOWN_DWELL_LOW       = 5'h07;
	localparam logic [4:0] GPIO_DIRECTION       = 5'h08;
	localparam logic [4:0] SEED_HIGH            = 5'h0a;
	localparam logic [4:0] SEED_LOW             = 5'h0b;
	localparam logic [4:0] DOWN_STEP_COUNT_HIGH = 5'h0c;
	localparam logic [4:0] DOWN_STEP_COUNT_LOW  = 5'h0d;
	localparam logic [4:0] SWEEP_CONTROL        = 5'h0e;
	localparam logic [4:0] UP_DWELL_HIGH        = 5'h10;
	localparam logic [4:0] UP_DWELL_LOW         = 5'h11;
	localparam logic [4:0] UP_STEP_SIZE_HIGH    = 5'h12;
	localparam logic [4:0] UP_STEP_SIZE_LOW     = 5'h13;
	localparam logic [4:0] UP_STEP_COUNT_HIGH   = 5'h14;
	localparam logic [4:0] UP_STEP_COUNT_LOW    = 5'h15;
	localparam logic [4:0] DOWN_STEP_SIZE_HIGH  = 5'h19;
	localparam logic [4:0] DOWN_STEP_SIZE_LOW   = 5'h1a;
	localparam logic [4:0] SWEEP_STATUS         = 5'h1b;

	// Field positions in sweep_control
	localparam int unsigned AUTO_LO_BIT    = 2;
	localparam int unsigned AUTO_HI_BIT    = 3;
	localparam int unsigned DELAY_EN_BIT   = 7;
	localparam int unsigned AUTOSEED_BIT   = 8;
	localparam int unsigned SWEEP_EN_BIT   = 11;
	localparam int unsigned TRIG_CMD_BIT   = 12;
	localparam int unsigned TRIG_SRC_BIT   = 13;
	localparam int unsigned SHAPE_BIT      = 22;
	localparam int unsigned ONE_WAY_BIT    = 25;
	localparam int unsigned DIR_BIT        = 26;
	// Field positions in the GPIO registers
	localparam int unsigned GPIO_MASTER_BIT = 4;
	localparam int unsigned TRIG_PIN_DIR_BIT = 13;

	// Values after reset
	localparam logic [29:0] REG_RESET   = 30'h0;
	localparam logic [20:0] DELAY_RESET = 21'h0;
	localparam logic [47:0] WIDE_RESET  = 48'h0;

	// Sweep engine states
	typedef enum logic [3:0] {
		SW_IDLE  = 4'b0001,
		SW_WAIT  = 4'b0010,
		SW_RAMP  = 4'b0100,
		SW_DWELL = 4'b1000
	} sweep_state_e;

	// Join a 30-bit upper and 18-bit lower register into one value
	function automatic logic [47:0] join48(input logic [29:0] hi,
		input logic [29:0] lo);
		join48 = {hi, lo[17:0]};
	endfunction : join48

endpackage : sweep_pkg

// File: design/trigger_delay.sv
// Programmable trigger delay counted in reference periods
module trigger_delay (
	// Clock and reset
	input  wire logic                      core_clk,
	input  wire logic                      rst_b,
	input  wire logic                      ce,
	// Configuration
	input  wire logic                      delayEn,
	input  wire logic [sweep_pkg::DELAY_W-1:0] delayCount,
	// Trigger in and out
	input  wire logic                      trigIn,
	output logic                           trigOut
);
	import sweep_pkg::*;

	logic                busy;
	logic [DELAY_W-1:0]  remain;

	// Count down from the programmed delay; later triggers ignored meanwhile
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			busy   <= 1'b0;
			remain <= DELAY_RESET;
		end else if (ce) begin
			if (!busy && trigIn && delayEn) begin
				busy   <= 1'b1;
				remain <= delayCount;
			end else if (busy && remain <= 21'h1) begin
				busy   <= 1'b0;
			end else if (busy) begin
				remain <= remain - 21'h1;
			end
		end
	end

	// Delay of one fires so the action lands on the next reference edge
	assign trigOut = delayEn ? (busy && remain <= 21'h1) : trigIn;

	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_b);

	sequence seq_arm_one;
		ce && !busy && trigIn && delayEn && delayCount == 21'h1;
	endsequence

	a_delay_one_edge: assert property (seq_arm_one |=> trigOut)
		else $error("delay of one did not fire on next edge");
	a_no_delay_pass: assert property (!delayEn && trigIn |-> trigOut)
		else $error("undelayed trigger was held back");
	a_delay_not_early: assert property (
		ce && !busy && trigIn && delayEn && delayCount == 21'h3
		|=> !trigOut ##1 (!trigOut || !$past(ce)))
		else $error("delayed trigger fired early");

endmodule : trigger_delay

// File: tb/host_model.sv
// Host controller model driving the serial register port
module host_model (
	// Clock
	input  wire logic                         core_clk,
	// Register port
	output logic                              regWrEn,
	output logic                              regRdEn,
	output logic [sweep_pkg::ADDR_W-1:0]      regAddr,
	output logic [sweep_pkg::DATA_W-1:0]      regWrData,
	input  wire logic [sweep_pkg::DATA_W-1:0] regRdData
);
	timeunit 1ns;
	timeprecision 1ps;
	import sweep_pkg::*;

	// Idle port at time zero
	initial begin
		regWrEn   = 1'b0;
		regRdEn   = 1'b0;
		regAddr   = 5'h00;
		regWrData = 30'h0;
	end

	// One write; released lines flip so stale data never lingers
	task automatic wr(input logic [4:0] a, input logic [29:0] d);
		@(posedge core_clk);
		regWrEn   <= 1'b1;
		regAddr   <= a;
		regWrData <= d;
		@(posedge core_clk);
		regWrEn   <= 1'b0;
		regAddr   <= ~a;
		regWrData <= ~d;
	endtask : wr

	// One read; data is taken once the answering edge has landed
	task automatic rd(input logic [4:0] a, output logic [29:0] d);
		@(posedge core_clk);
		regRdEn <= 1'b1;
		regAddr <= a;
		@(posedge core_clk);
		regRdEn <= 1'b0;
		regAddr <= ~a;
		#1;
		d = regRdData;
	endtask : rd

endmodule : host_model

// File: tb/tb_top.sv
// Self-checking bench of the frequency-sweep control block
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import sweep_pkg::*;

	// Down step joins upper 1 and lower 7; seed joins 1 and 2
	localparam logic [47:0] STEP_DN = 48'h40007;
	localparam logic [47:0] SEED    = 48'h40002;
	// Sweep parameter writes as {address, data}
	localparam logic [34:0] CFG [9] = '{{5'h11, 30'h2}, {5'h13, 30'h2aac0005},
		{5'h15, 30'h4}, {5'h07, 30'h1}, {5'h19, 30'h1}, {5'h1a, 30'h7},
		{5'h0d, 30'h3}, {5'h0a, 30'h1}, {5'h0b, 30'h2}};

	typedef struct {
		logic [29:0] ctrl;
		logic [20:0] dly;
		int          lat;
		int          n1;
		logic [47:0] off1;
		int          d1;
		int          n2;
		logic [47:0] off2;
		int          d2;
		logic        sd;
	} row_s;

	row_s        rows [4];
	logic        core_clk, rst_b, ce, regWrEn, regRdEn, gpioTriggerPin;
	logic        rampUp, rampActive, dwellActive, seedLoad, sweepTrigger;
	logic [4:0]  regAddr;
	logic [29:0] regWrData, regRdData;
	logic [47:0] freqOffset, seedValue;
	int          nMismatch, checked;

	// Clock of 8 ns
	initial core_clk = 1'b0;
	always #4 core_clk = ~core_clk;

	frequency_sweep_control dut_u (
		.core_clk(core_clk), .rst_b(rst_b), .ce(ce),
		.regWrEn(regWrEn), .regRdEn(regRdEn), .regAddr(regAddr),
		.regWrData(regWrData), .regRdData(regRdData),
		.gpioTriggerPin(gpioTriggerPin), .freqOffset(freqOffset),
		.rampUp(rampUp), .rampActive(rampActive), .dwellActive(dwellActive),
		.seedLoad(seedLoad), .seedValue(seedValue), .sweepTrigger(sweepTrigger)
	);

	host_model host_u (
		.core_clk(core_clk), .regWrEn(regWrEn), .regRdEn(regRdEn),
		.regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData)
	);

	// Compare and count
	task automatic check(input string nm, input logic [47:0] seen, exp);
		checked++;
		if (seen !== exp) begin
			nMismatch++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check

	// Verdict and end of run
	task automatic end_of_test();
		$display("Comparisons %0d mismatches %0d", checked, nMismatch);
		if (nMismatch == 0 && checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : end_of_test

	// Synchronous reset for three cycles
	task automatic reset_dut();
		@(posedge core_clk);
		rst_b <= 1'b0;
		repeat (3) @(posedge core_clk);
		rst_b <= 1'b1;
		@(posedge core_clk);
	endtask : reset_dut

	// Program dwell, step and count sets plus the seed
	task automatic config_regs();
		foreach (CFG[k]) host_u.wr(CFG[k][34:30], CFG[k][29:0]);
	endtask : config_regs

	// Register trigger; cycles from accepting edge to ramp start
	task automatic fire(input logic [29:0] c, output int lat, output logic saw);
		fork
			host_u.wr(SWEEP_CONTROL, c | 30'h1000);
			begin
				@(posedge core_clk);
				#1;
				saw = sweepTrigger;
			end
		join
		#1;
		lat = 0;
		while (lat < 40 && rampActive !== 1'b1) begin
			saw |= sweepTrigger;
			@(posedge core_clk);
			#1;
			lat++;
		end
	endtask : fire

	// Length of ramp and following dwell, and any seed reload
	task automatic ramp(output int n, output int d, output logic sd);
		n  = 0;
		d  = 0;
		sd = 1'b0;
		while (rampActive === 1'b1 && n < 100) begin
			sd |= seedLoad;
			@(posedge core_clk);
			#1;
			n++;
		end
		while (dwellActive === 1'b1 && d < 100) begin
			@(posedge core_clk);
			#1;
			d++;
		end
	endtask : ramp

	// Whether a ramp starts within a number of cycles
	task automatic watch(input int cyc, output logic seen);
		seen = 1'b0;
		repeat (cyc) begin
			@(posedge core_clk);
			#1;
			seen |= rampActive;
		end
	endtask : watch

	// Pin pulse, high and low long enough for the synchroniser
	task automatic pulse_pin();
		@(posedge core_clk);
		gpioTriggerPin <= 1'b1;
		repeat (4) @(posedge core_clk);
		gpioTriggerPin <= 1'b0;
	endtask : pulse_pin

	// Watchdog well beyond the expected run length
	initial begin
		repeat (20000) @(posedge core_clk);
		nMismatch++;
		end_of_test();
	end

	// Main sequence
	initial begin
		int          lat, n, d;
		logic        saw, sd, seen;
		logic [29:0] rdVal;
		rst_b          = 1'b0;
		ce             = 1'b1;
		gpioTriggerPin = 1'b0;
		nMismatch      = 0;
		checked        = 0;
		rows[0] = '{30'h04400900, 21'h0, 0, 4, 48'd20, 2, 4, 48'd0, 2, 1'b1};
		rows[1] = '{30'h04400880, 21'h1, 1, 4, 48'd20, 2, 4, 48'd0, 2, 1'b0};
		rows[2] = '{30'h00000880, 21'h3, 3, 3, 48'd0 - 48'd3 * STEP_DN, 1,
			4, 48'd20 - 48'd3 * STEP_DN, 2, 1'b0};
		rows[3] = '{30'h06400800, 21'h0, 0, 4, 48'd0, 2, 4, 48'd0, 2, 1'b0};
		repeat (3) @(posedge core_clk);
		rst_b <= 1'b1;
		@(posedge core_clk);
		#1;
		// Reset values, disabled sweep, refused writes
		check("rampUp", rampUp, 1);
		check("freqOffset", freqOffset, 0);
		check("regRdData", regRdData, 0);
		host_u.wr(SWEEP_CONTROL, 30'h1000);
		watch(8, seen);
		check("disabled trigger", seen, 0);
		host_u.wr(SWEEP_STATUS, 30'h3fffffff);
		host_u.wr(5'h1f, 30'h3fffffff);
		host_u.rd(5'h1f, rdVal);
		check("unmapped", rdVal, 0);
		host_u.rd(SWEEP_STATUS, rdVal);
		check("status idle", rdVal, 30'h21);
		$display("Reset and register test done");
		// Ordinary sweep cases, two ramps each
		foreach (rows[i]) begin
			reset_dut();
			config_regs();
			host_u.wr(TRIGGER_DELAY_COUNT, {9'h0, rows[i].dly});
			host_u.wr(SWEEP_CONTROL, rows[i].ctrl);
			for (int p = 0; p < 2; p++) begin
				fire(rows[i].ctrl, lat, saw);
				check("latency", lat, rows[i].lat);
				check("trigger", saw, 1);
				ramp(n, d, sd);
				check("steps", n, p ? rows[i].n2 : rows[i].n1);
				check("offset", freqOffset,
					p ? rows[i].off2 : rows[i].off1);
				check("dwell", d, p ? rows[i].d2 : rows[i].d1);
				check("seedLoad", sd, rows[i].sd);
			end
			if (rows[i].sd) check("seedValue", seedValue, SEED);
			$display("Sweep case %0d done", i);
		end
		host_u.rd(UP_STEP_SIZE_LOW, rdVal);
		check("low register", rdVal, 30'h2aac0005);
		host_u.rd(SWEEP_CONTROL, rdVal);
		check("control", rdVal, 30'h06400800);
		// Automatic two-way sweep, clock enable held low mid-ramp
		reset_dut();
		config_regs();
		host_u.wr(SWEEP_CONTROL, 30'h0440080c);
		watch(2, seen);
		check("auto start", seen, 1);
		ramp(n, d, sd);
		check("auto steps", n, 4);
		check("auto dwell", d, 2);
		check("auto turn", {rampActive, rampUp}, 2'h2);
		check("auto peak", freqOffset, 48'h14);
		@(posedge core_clk);
		ce <= 1'b0;
		repeat (3) @(posedge core_clk);
		ce <= 1'b1;
		#1;
		check("frozen offset", freqOffset, 48'hf);
		ramp(n, d, sd);
		check("steps after hold", n, 3);
		check("auto fall offset", freqOffset, 48'h0);
		$display("Automatic sweep test done");
		// Pin trigger source and its enables; reset lands mid-ramp
		reset_dut();
		#1;
		check("reset flags", {rampActive, dwellActive, seedLoad,
			sweepTrigger, rampUp}, 5'h01);
		check("reset offset", freqOffset, 48'h0);
		check("reset read data", regRdData, 30'h0);
		config_regs();
		host_u.wr(SWEEP_CONTROL, 30'h04403800);
		watch(8, seen);
		check("register trigger with pin source", seen, 0);
		fork
			pulse_pin();
			watch(12, seen);
		join
		check("pin without master enable", seen, 0);
		host_u.wr(GPIO_MASTER_CONTROL, 30'h10);
		host_u.wr(GPIO_DIRECTION, 30'h2000);
		fork
			pulse_pin();
			watch(12, seen);
		join
		check("pin set as output", seen, 0);
		host_u.wr(GPIO_DIRECTION, 30'h0);
		fork
			pulse_pin();
			watch(12, seen);
		join
		check("pin trigger", seen, 1);
		$display("Pin trigger test done");
		end_of_test();
	end

endmodule : tb_top
